// ===== logic/crs_defines.vh
// Register offsets, field positions, reset values and operation codes of the core register state.
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH

// ------------------------------------------------------------
// Bus offsets (byte addresses)
// ------------------------------------------------------------
`define CRS_OFS_STACK   12'h000
`define CRS_OFS_DP_LO   12'h004
`define CRS_OFS_DP_HI   12'h008
`define CRS_OFS_MAIN    12'h00C
`define CRS_OFS_SECOND  12'h010
`define CRS_OFS_STATUS  12'h014
`define CRS_OFS_PCL     12'h018
`define CRS_OFS_PCH     12'h01C
`define CRS_OFS_OPCTRL  12'h020
`define CRS_OFS_OPARG   12'h024
`define CRS_OFS_RESULT  12'h028
`define CRS_OFS_WREG    12'h040

// ------------------------------------------------------------
// Status word field positions
// ------------------------------------------------------------
`define CRS_SW_CARRY     7
`define CRS_SW_AUXC      6
`define CRS_SW_USER      5
`define CRS_SW_BANK_HI   4
`define CRS_SW_BANK_LO   3
`define CRS_SW_SIGN_ERR  2
`define CRS_SW_P    0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CRS_RST_STACK  8'h07
`define CRS_RST_PC     16'h0000
`define CRS_RST_BYTE   8'h00

// ------------------------------------------------------------
// Operation codes written to the operation control register
// ------------------------------------------------------------
`define CRS_OP_NONE  4'h0
`define CRS_OP_ADD   4'h1
`define CRS_OP_ADDC  4'h2
`define CRS_OP_SUBB  4'h3
`define CRS_OP_MUL   4'h4
`define CRS_OP_DIV   4'h5
`define CRS_OP_CLR_SIGN 4'h6
`define CRS_OP_PUSH  4'h7
`define CRS_OP_POP   4'h8
`define CRS_OP_RLC   4'h9
`define CRS_OP_RRC   4'hA
`define CRS_OP_INCPC 4'hB
`define CRS_OP_INCDP 4'hC

`endif

// ===== logic/crs_bank_mem.v
// Working register banks and stack area held in a small internal data memory.
`timescale 1ns/1ps

module crs_bank_mem #(
	parameter AW = 6
) (
	input  wire          hclk,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [7:0]    wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [7:0]    rd_data
);

	reg [7:0] mem [0:(1<<AW)-1];

	// ------------------------------------------------------------
	// Synchronous write and registered read
	// ------------------------------------------------------------
	// Read data is registered so the caller sees it one cycle later.
	always @(posedge hclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end

endmodule

// ===== logic/crs_parity.v
// Odd parity of one byte.
`timescale 1ns/1ps

module crs_parity (
	input  wire [7:0] data_in,
	output wire       odd_out
);

	// Reduction XOR gives one when the count of ones is odd.
	assign odd_out = ^data_in;

endmodule

// ===== logic/crs_core_regs.v
// Core architectural register state behind an AHB-Lite slave port.
//
// Operation
// - Stack pointer is an eight-bit register holding top of stack.
// - Push increments pointer before writing; pop reads then decrements.
// - Reset loads stack pointer with 07h so first push hits 08h.
// - Data pointer is sixteen bits from separately accessible low and high bytes.
// - Data pointer serves as base address and as plain sixteen-bit data.
// - Sixteen-bit program counter of two bytes, reset to 0000h.
// - Multiply and divide use accumulator with second operand as sixteen bits.
// - Four banks of eight working registers at internal locations 00h-1Fh.
// - Two bank-select bits choose the active bank's eight-location window.
// - After reset bank zero is active, working registers at 00h-07h.
// - Carry set by add carry or subtract borrow; shifts update it too.
// - Auxiliary carry set on carry into or borrow from upper nibble.
// - Overflow set on signed change, product above 255, or zero divisor.
// - Add, subtract, multiply and divide clear overflow when no overflow.
// - Clear-overflow operation clears the overflow flag unconditionally.
// - Parity flag set when accumulator holds an odd count of ones.
// - User flag changes only by software, no result affects it.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "crs_defines.vh"

module crs_core_regs (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	output reg  [15:0] program_counter,
	output reg  [15:0] data_pointer_pair,
	output reg  [7:0]  stack_top_pointer
);

	// ------------------------------------------------------------
	// Architectural registers
	// ------------------------------------------------------------
	reg  [7:0]  acc_r;
	reg  [7:0]  second_r;
	reg         carry_flag_r;
	reg         aux_carry_flag_r;
	reg         user_flag_zero_r;
	reg         bank_select_high_r;
	reg         bank_select_low_r;
	reg         sign_error_flag_r;
	reg  [7:0]  oparg_r;
	reg  [7:0]  result_r;
	wire        parity_flag;
	wire [7:0]  status_word_reg;
	wire [7:0]  mem_rd_data;

	// ------------------------------------------------------------
	// Bus pipeline state
	// ------------------------------------------------------------
	reg         dph_r;
	reg         dph_write_r;
	reg  [11:0] dph_addr_r;
	reg         rd_pend_r;
	reg         pop_pend_r;
	reg         byp_hit_r;
	reg  [7:0]  byp_data_r;

	// Parity follows the accumulator with no clock in between.
	crs_parity u_par (
		.data_in (acc_r),
		.odd_out (parity_flag)
	);

	// Status word layout; bit 1 is unused and reads zero.
	assign status_word_reg = {carry_flag_r, aux_carry_flag_r, user_flag_zero_r,
		bank_select_high_r, bank_select_low_r, sign_error_flag_r, 1'b0, parity_flag};

	// ------------------------------------------------------------
	// Address phase capture
	// ------------------------------------------------------------
	wire addr_valid = hsel & hready & htrans[1];

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_r       <= 1'b0;
			dph_write_r <= 1'b0;
			dph_addr_r  <= 12'h000;
		end
		else
		begin
			dph_r       <= addr_valid;
			dph_write_r <= addr_valid & hwrite;
			dph_addr_r  <= haddr[11:0];
		end
	end

	// ------------------------------------------------------------
	// Working register window
	// ------------------------------------------------------------
	// Bank bits form the top of the 5-bit address; index is the low three.
	wire [2:0] wreg_idx  = dph_addr_r[4:2];
	wire [5:0] wreg_addr = {1'b0, bank_select_high_r, bank_select_low_r, wreg_idx};
	wire       wreg_hit  = (dph_addr_r[11:5] == `CRS_OFS_WREG >> 5);
	wire       ahead_rd  = addr_valid & ~hwrite &
		(haddr[11:5] == `CRS_OFS_WREG >> 5);
	// A status write in its data phase moves the bank at the same edge that
	// takes a following window read, so that read must use the incoming bits.
	wire       sw_wr_now = dph_write_r & (dph_addr_r == `CRS_OFS_STATUS);
	wire [1:0] bank_now  = sw_wr_now ? {hwdata[`CRS_SW_BANK_HI], hwdata[`CRS_SW_BANK_LO]} :
		{bank_select_high_r, bank_select_low_r};
	wire [5:0] ahead_rd_addr = {1'b0, bank_now, haddr[4:2]};

	// ------------------------------------------------------------
	// Operation execution decode
	// ------------------------------------------------------------
	wire       op_go  = dph_write_r & (dph_addr_r == `CRS_OFS_OPCTRL);
	wire [3:0] op_code = hwdata[3:0];

	// Sums carry one extra bit so carry and nibble carry fall out directly.
	wire       cin      = (op_code == `CRS_OP_ADDC) ? carry_flag_r : 1'b0;
	wire [8:0] add_sum  = {1'b0, acc_r} + {1'b0, oparg_r} + {8'h00, cin};
	wire [4:0] add_nib  = {1'b0, acc_r[3:0]} + {1'b0, oparg_r[3:0]} + {4'h0, cin};
	wire [8:0] sub_dif  = {1'b0, acc_r} - {1'b0, oparg_r} - {8'h00, carry_flag_r};
	wire [4:0] sub_nib  = {1'b0, acc_r[3:0]} - {1'b0, oparg_r[3:0]} - {4'h0, carry_flag_r};
	wire [15:0] mul_res = acc_r * second_r;
	wire [7:0] div_q    = (second_r == 8'h00) ? 8'h00 : acc_r / second_r;
	wire [7:0] div_r    = (second_r == 8'h00) ? 8'h00 : acc_r % second_r;
	wire       add_serr = (acc_r[7] == oparg_r[7]) & (add_sum[7] != acc_r[7]);
	wire       sub_serr = (acc_r[7] != oparg_r[7]) & (sub_dif[7] != acc_r[7]);

	// Stack push writes the incremented address; pop reads the current one.
	wire [7:0] sp_inc   = stack_top_pointer + 8'h01;
	wire       do_push  = op_go & (op_code == `CRS_OP_PUSH);
	wire       do_pop   = op_go & (op_code == `CRS_OP_POP);
	wire       wreg_wr  = dph_write_r & wreg_hit;

	// Memory write port: push has priority over a window write in the same cycle.
	wire       mem_we   = do_push | wreg_wr;
	wire [5:0] mem_wa   = do_push ? sp_inc[5:0] : wreg_addr;
	wire [7:0] mem_wd   = do_push ? oparg_r : hwdata[7:0];
	wire [5:0] mem_ra   = ahead_rd ? ahead_rd_addr : stack_top_pointer[5:0];

	crs_bank_mem #(
		.AW (6)
	) u_mem (
		.hclk    (hclk),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (mem_wd),
		.rd_addr (mem_ra),
		.rd_data (mem_rd_data)
	);

	// ------------------------------------------------------------
	// Write bypass for back-to-back window accesses
	// ------------------------------------------------------------
	// The memory returns the old byte when a location is read at the edge
	// that writes it, so the new byte is kept aside for that one case.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			byp_hit_r  <= 1'b0;
			byp_data_r <= `CRS_RST_BYTE;
		end
		else
		begin
			byp_hit_r  <= ahead_rd & mem_we & (mem_wa == ahead_rd_addr);
			byp_data_r <= mem_wd;
		end
	end

	// ------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------
	// Software writes and executed operations share this one process.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stack_top_pointer  <= `CRS_RST_STACK;
			program_counter    <= `CRS_RST_PC;
			data_pointer_pair  <= {`CRS_RST_BYTE, `CRS_RST_BYTE};
			acc_r              <= `CRS_RST_BYTE;
			second_r           <= `CRS_RST_BYTE;
			oparg_r            <= `CRS_RST_BYTE;
			result_r           <= `CRS_RST_BYTE;
			carry_flag_r       <= 1'b0;
			aux_carry_flag_r   <= 1'b0;
			user_flag_zero_r   <= 1'b0;
			bank_select_high_r <= 1'b0;
			bank_select_low_r  <= 1'b0;
			sign_error_flag_r  <= 1'b0;
			pop_pend_r         <= 1'b0;
		end
		else
		begin
			pop_pend_r <= do_pop;
			// A pop first reads at the old pointer, then moves it down.
			if (pop_pend_r)
				result_r <= mem_rd_data;
			if (dph_write_r)
			begin
				if (dph_addr_r == `CRS_OFS_STACK)
					stack_top_pointer <= hwdata[7:0];
				else if (dph_addr_r == `CRS_OFS_DP_LO)
					data_pointer_pair[7:0] <= hwdata[7:0];
				else if (dph_addr_r == `CRS_OFS_DP_HI)
					data_pointer_pair[15:8] <= hwdata[7:0];
				else if (dph_addr_r == `CRS_OFS_MAIN)
					acc_r <= hwdata[7:0];
				else if (dph_addr_r == `CRS_OFS_SECOND)
					second_r <= hwdata[7:0];
				else if (dph_addr_r == `CRS_OFS_PCL)
					program_counter[7:0] <= hwdata[7:0];
				else if (dph_addr_r == `CRS_OFS_PCH)
					program_counter[15:8] <= hwdata[7:0];
				else if (dph_addr_r == `CRS_OFS_OPARG)
					oparg_r <= hwdata[7:0];
				else if (dph_addr_r == `CRS_OFS_STATUS)
				begin
					// The user flag moves only here, by software.
					carry_flag_r       <= hwdata[`CRS_SW_CARRY];
					aux_carry_flag_r   <= hwdata[`CRS_SW_AUXC];
					user_flag_zero_r   <= hwdata[`CRS_SW_USER];
					bank_select_high_r <= hwdata[`CRS_SW_BANK_HI];
					bank_select_low_r  <= hwdata[`CRS_SW_BANK_LO];
					sign_error_flag_r  <= hwdata[`CRS_SW_SIGN_ERR];
				end
				else if (op_go)
				begin
					case (op_code)
					`CRS_OP_ADD, `CRS_OP_ADDC:
					begin
						acc_r             <= add_sum[7:0];
						carry_flag_r      <= add_sum[8];
						aux_carry_flag_r  <= add_nib[4];
						sign_error_flag_r <= add_serr;
					end
					`CRS_OP_SUBB:
					begin
						acc_r             <= sub_dif[7:0];
						carry_flag_r      <= sub_dif[8];
						aux_carry_flag_r  <= sub_nib[4];
						sign_error_flag_r <= sub_serr;
					end
					`CRS_OP_MUL:
					begin
						acc_r             <= mul_res[7:0];
						second_r          <= mul_res[15:8];
						carry_flag_r      <= 1'b0;
						aux_carry_flag_r  <= 1'b0;
						sign_error_flag_r <= (mul_res > 16'h00FF);
					end
					`CRS_OP_DIV:
					begin
						acc_r             <= div_q;
						second_r          <= div_r;
						carry_flag_r      <= 1'b0;
						aux_carry_flag_r  <= 1'b0;
						sign_error_flag_r <= (second_r == 8'h00);
					end
					`CRS_OP_CLR_SIGN:
						sign_error_flag_r <= 1'b0;
					`CRS_OP_PUSH:
						stack_top_pointer <= sp_inc;
					`CRS_OP_POP:
						stack_top_pointer <= stack_top_pointer - 8'h01;
					`CRS_OP_RLC:
					begin
						acc_r        <= {acc_r[6:0], carry_flag_r};
						carry_flag_r <= acc_r[7];
					end
					`CRS_OP_RRC:
					begin
						acc_r        <= {carry_flag_r, acc_r[7:1]};
						carry_flag_r <= acc_r[0];
					end
					`CRS_OP_INCPC:
						program_counter <= program_counter + 16'h0001;
					`CRS_OP_INCDP:
						data_pointer_pair <= data_pointer_pair + 16'h0001;
					default:
						result_r <= result_r;
					endcase
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Read data and wait state
	// ------------------------------------------------------------
	// Window reads need one wait cycle for the registered memory output;
	// all other reads answer with no wait.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_pend_r <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end
		else
		begin
			hresp <= 1'b0;
			if (ahead_rd)
			begin
				rd_pend_r <= 1'b1;
				hreadyout <= 1'b0;
			end
			else if (rd_pend_r)
			begin
				rd_pend_r <= 1'b0;
				hreadyout <= 1'b1;
				hrdata    <= {24'h000000, (byp_hit_r ? byp_data_r : mem_rd_data)};
			end
			else if (addr_valid & ~hwrite)
			begin
				hreadyout <= 1'b1;
				if (haddr[11:0] == `CRS_OFS_STACK)
					hrdata <= {24'h000000, stack_top_pointer};
				else if (haddr[11:0] == `CRS_OFS_DP_LO)
					hrdata <= {24'h000000, data_pointer_pair[7:0]};
				else if (haddr[11:0] == `CRS_OFS_DP_HI)
					hrdata <= {24'h000000, data_pointer_pair[15:8]};
				else if (haddr[11:0] == `CRS_OFS_MAIN)
					hrdata <= {24'h000000, acc_r};
				else if (haddr[11:0] == `CRS_OFS_SECOND)
					hrdata <= {24'h000000, second_r};
				else if (haddr[11:0] == `CRS_OFS_STATUS)
					hrdata <= {24'h000000, status_word_reg};
				else if (haddr[11:0] == `CRS_OFS_PCL)
					hrdata <= {24'h000000, program_counter[7:0]};
				else if (haddr[11:0] == `CRS_OFS_PCH)
					hrdata <= {24'h000000, program_counter[15:8]};
				else if (haddr[11:0] == `CRS_OFS_OPARG)
					hrdata <= {24'h000000, oparg_r};
				else if (haddr[11:0] == `CRS_OFS_RESULT)
					hrdata <= {24'h000000, result_r};
				else
					hrdata <= 32'h00000000;
			end
			else
				hreadyout <= 1'b1;
		end
	end

endmodule

// ===== verification/crs_core_regs_sva.sv
// Checker of the core register state bus and register ports.
`timescale 1ns/1ps

module crs_core_regs_sva (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire [15:0] program_counter,
	input wire [15:0] data_pointer_pair,
	input wire [7:0]  stack_top_pointer
);
	// ------------------------------------------------------------
	// Cycles since the last write request
	// ------------------------------------------------------------
	logic       wr_req;
	logic [2:0] since_wr_r;

	// Saturates so that a long idle stretch never wraps back into the window.
	assign wr_req = hsel && hready && htrans[1] && hwrite;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			since_wr_r <= 3'h7;
		else if (wr_req)
			since_wr_r <= 3'h0;
		else if (since_wr_r != 3'h7)
			since_wr_r <= since_wr_r + 3'h1;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_sp_rst; $rose(hresetn) |-> stack_top_pointer == 8'h07; endproperty
	property p_pc_rst; $rose(hresetn) |-> program_counter == 16'h0000; endproperty
	property p_dp_rst; $rose(hresetn) |-> data_pointer_pair == 16'h0000; endproperty
	property p_sp_cause; !$stable(stack_top_pointer) |-> since_wr_r <= 3'h3; endproperty
	property p_pc_cause; !$stable(program_counter) |-> since_wr_r <= 3'h3; endproperty
	property p_dp_cause; !$stable(data_pointer_pair) |-> since_wr_r <= 3'h3; endproperty
	property p_rdy_wait; !hreadyout |=> hreadyout; endproperty
	// Only a read of the working register window (0x40 to 0x5C) may wait.
	property p_rdy_cause;
		$fell(hreadyout) |-> $past(hsel && hready && htrans[1] && !hwrite &&
			haddr[11:5] == 7'h02);
	endproperty
	property p_byte; hreadyout |-> hrdata[31:8] == 24'h000000; endproperty

	a_sp_rst: assert property (p_sp_rst) else $error("stack reset value");
	a_pc_rst: assert property (p_pc_rst) else $error("pc reset value");
	a_dp_rst: assert property (p_dp_rst) else $error("data pointer reset value");
	a_sp_cause: assert property (p_sp_cause) else $error("stack moved alone");
	a_pc_cause: assert property (p_pc_cause) else $error("pc moved alone");
	a_dp_cause: assert property (p_dp_cause) else $error("data_pointer_pair moved alone");
	a_rdy_wait: assert property (p_rdy_wait) else $error("wait too long");
	a_rdy_cause: assert property (p_rdy_cause) else $error("stray wait");
	a_byte: assert property (p_byte) else $error("upper read bits set");

	c_wait: cover property ($fell(hreadyout));
	c_push: cover property (stack_top_pointer == 8'h09);
	c_pc: cover property (program_counter == 16'h1300);
endmodule

bind crs_core_regs crs_core_regs_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready,
	.hrdata, .hreadyout, .program_counter, .data_pointer_pair, .stack_top_pointer);

// ===== verification/tb.sv
// Self-checking testbench of the core register state.
`timescale 1ns/1ps
`include "crs_defines.vh"

module tb;
	// ------------------------------------------------------------
	// Signals and design
	// ------------------------------------------------------------
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b1;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	wire         hready;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire  [15:0] program_counter;
	wire  [15:0] data_pointer_pair;
	wire  [7:0]  stack_top_pointer;
	int          error_cnt = 0;
	int          check_count = 0;
	logic [7:0]  rd_q;
	// Columns: op, acc, operand, second, status in, acc out, second out, status out.
	logic [7:0]  alu_t [0:11][0:7] = '{
		'{8'h01, 8'h7F, 8'h01, 8'h00, 8'h20, 8'h80, 8'h00, 8'h64},
		'{8'h01, 8'hFF, 8'h01, 8'h00, 8'h20, 8'h00, 8'h00, 8'hE0},
		'{8'h02, 8'h01, 8'h01, 8'h00, 8'hA0, 8'h03, 8'h00, 8'h20},
		'{8'h03, 8'h00, 8'h01, 8'h00, 8'h20, 8'hFF, 8'h00, 8'hE0},
		'{8'h03, 8'h80, 8'h01, 8'h00, 8'h20, 8'h7F, 8'h00, 8'h64},
		'{8'h04, 8'h10, 8'h00, 8'h10, 8'h20, 8'h00, 8'h01, 8'h24},
		'{8'h04, 8'h03, 8'h00, 8'h04, 8'hE0, 8'h0C, 8'h00, 8'h20},
		'{8'h05, 8'h0D, 8'h00, 8'h04, 8'h24, 8'h03, 8'h01, 8'h20},
		'{8'h05, 8'h0D, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h24},
		'{8'h06, 8'h5A, 8'h00, 8'h00, 8'h24, 8'h5A, 8'h00, 8'h20},
		'{8'h09, 8'h81, 8'h00, 8'h00, 8'h20, 8'h02, 8'h00, 8'hA0},
		'{8'h0A, 8'h01, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'hA0}};

	// The single slave answers its own wait states, so ready loops back.
	assign hready = hreadyout;
	always #25 hclk = ~hclk;

	crs_core_regs u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .program_counter, .data_pointer_pair,
		.stack_top_pointer);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One single transfer; every phase is held until ready is sampled high.
	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge hclk);
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hready !== 1'b1);
		rd_q = hrdata[7:0];
		check("hresp", {15'h0000, hresp}, 16'h0000);
	endtask

	// Write then read, the read's address phase riding on the write's data phase.
	task automatic b2b(input logic [11:0] wa, input logic [7:0] d, input logic [11:0] ra);
		@(posedge hclk);
		haddr <= {20'h00000, wa};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		do @(posedge hclk); while (hready !== 1'b1);
		haddr <= {20'h00000, ra};
		hwrite <= 1'b0;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		do @(posedge hclk); while (hready !== 1'b1);
		rd_q = hrdata[7:0];
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [7:0] exp, input string n);
		bus(1'b0, a, 8'h00);
		check(n, {8'h00, rd_q}, {8'h00, exp});
	endtask

	// Pops have their result one cycle after the write; every operation is followed by two idle cycles.
	task automatic op(input logic [3:0] c);
		wr(`CRS_OFS_OPCTRL, {4'h0, c});
		repeat (2) @(posedge hclk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		check("sp_port", {8'h00, stack_top_pointer}, 16'h0007);
		check("pc_port", program_counter, 16'h0000);
		rchk(`CRS_OFS_STACK, 8'h07, "sp_reg");
		rchk(`CRS_OFS_STATUS, 8'h00, "status_rst");
	endtask

	task automatic t_stack;
		wr(`CRS_OFS_OPARG, 8'hA5);
		op(`CRS_OP_PUSH);
		wr(`CRS_OFS_OPARG, 8'h3C);
		op(`CRS_OP_PUSH);
		check("sp_push", {8'h00, stack_top_pointer}, 16'h0009);
		wr(`CRS_OFS_STATUS, 8'h08);
		rchk(`CRS_OFS_WREG, 8'hA5, "first_push");
		rchk(`CRS_OFS_WREG + 12'h004, 8'h3C, "second_push");
		op(`CRS_OP_POP);
		rchk(`CRS_OFS_RESULT, 8'h3C, "pop_one");
		check("sp_pop", {8'h00, stack_top_pointer}, 16'h0008);
		op(`CRS_OP_POP);
		rchk(`CRS_OFS_RESULT, 8'hA5, "pop_two");
	endtask

	task automatic t_banks;
		for (int b = 0; b < 4; b++)
		begin
			wr(`CRS_OFS_STATUS, 8'(b << 3));
			wr(`CRS_OFS_WREG + 12'h01C, 8'hC0 + 8'(b));
		end
		for (int b = 0; b < 4; b++)
		begin
			wr(`CRS_OFS_STATUS, 8'(b << 3));
			rchk(`CRS_OFS_WREG + 12'h01C, 8'hC0 + 8'(b), "bank_r7");
		end
		wr(`CRS_OFS_STATUS, 8'h08);
		rchk(`CRS_OFS_WREG, 8'hA5, "bank1_r0");
	endtask

	// Bank 2 R7 holds C2 from the bank scenario; bank 1 is active on entry.
	task automatic t_pipe;
		b2b(`CRS_OFS_STATUS, 8'h10, `CRS_OFS_WREG + 12'h01C);
		check("pipe_bank", {8'h00, rd_q}, 16'h00C2);
		b2b(`CRS_OFS_WREG + 12'h01C, 8'h5E, `CRS_OFS_WREG + 12'h01C);
		check("pipe_wreg", {8'h00, rd_q}, 16'h005E);
	endtask

	task automatic t_alu;
		for (int i = 0; i < 12; i++)
		begin
			wr(`CRS_OFS_MAIN, alu_t[i][1]);
			wr(`CRS_OFS_SECOND, alu_t[i][3]);
			wr(`CRS_OFS_STATUS, alu_t[i][4]);
			wr(`CRS_OFS_OPARG, alu_t[i][2]);
			op(alu_t[i][0][3:0]);
			rchk(`CRS_OFS_MAIN, alu_t[i][5], "alu_acc");
			rchk(`CRS_OFS_SECOND, alu_t[i][6], "alu_second");
			rchk(`CRS_OFS_STATUS, alu_t[i][7] | {7'h00, ^alu_t[i][5]}, "alu_status");
		end
	endtask

	task automatic t_ptr;
		wr(`CRS_OFS_PCL, 8'hFF);
		wr(`CRS_OFS_PCH, 8'h12);
		op(`CRS_OP_INCPC);
		check("pc_inc", program_counter, 16'h1300);
		wr(`CRS_OFS_DP_LO, 8'hFF);
		wr(`CRS_OFS_DP_HI, 8'h0A);
		op(`CRS_OP_INCDP);
		check("dp_inc", data_pointer_pair, 16'h0B00);
		rchk(`CRS_OFS_DP_HI, 8'h0B, "dp_high");
		rchk(`CRS_OFS_DP_LO, 8'h00, "dp_low");
	endtask

	task automatic t_unmapped;
		wr(12'h03C, 8'h55);
		rchk(12'h03C, 8'h00, "unmapped");
		rchk(`CRS_OFS_STACK, 8'h07, "sp_kept");
	endtask

	// ------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_stack;
		t_banks;
		t_pipe;
		t_alu;
		t_ptr;
		t_unmapped;
		results;
	end

	// The whole run needs under 500 cycles; this leaves ample margin.
	initial
	begin
		repeat (6000) @(posedge hclk);
		error_cnt++;
		results;
	end
endmodule
